// ===== hw/pwa_alu.sv
// word-accumulator arithmetic, step and compare datapath
`timescale 1ns/1ns
module pwa_alu #(
  parameter int IDX_W = pwa_pkg::IDX_W_DEF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // command from the sequencer
  input wire logic i_req_valid,
  input wire pwa_pkg::pwa_req_t i_req,
  output logic o_ready,
  output logic o_done,
  output logic o_reject,
  // accumulators and index register
  output logic [pwa_pkg::ACC_W-1:0] o_acc,
  output logic [IDX_W-1:0] o_idx,
  output logic o_logic_acc,
  output logic o_logic_mode,
  // error markers
  output pwa_pkg::pwa_err_t o_err,
  // operand write-back to memory
  output pwa_pkg::pwa_wr_t o_wr
);
  import pwa_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIX} pwa_state_t;

  typedef struct packed {
    pwa_state_t st;
    logic ready;
    logic done;
    logic reject;
    logic [ACC_W-1:0] acc;
    logic [IDX_W-1:0] idx;
    logic lacc;
    logic lmode;
    pwa_err_t err;
    pwa_wr_t wr;
    logic [ACC_W-1:0] quo;
    logic [ACC_W-1:0] part;
    logic [ACC_W-1:0] dsr;
    logic [CNT_W-1:0] cnt;
    logic q_neg;
    logic r_neg;
    logic is_rem;
  } pwa_regs_t;

  localparam pwa_regs_t RST_S = '{
    st: ST_IDLE, ready: 1'b1, done: 1'b0, reject: 1'b0,
    acc: ACC_RST, idx: '0, lacc: 1'b0, lmode: 1'b0,
    err: '0, wr: '{valid: 1'b0, kind: KIND_BYTE, data: ACC_RST},
    quo: ACC_RST, part: ACC_RST, dsr: ACC_RST, cnt: '0,
    q_neg: 1'b0, r_neg: 1'b0, is_rem: 1'b0
  };

  pwa_regs_t s_reg;
  pwa_regs_t s_next;

  // sign-extend the low bits that the operand kind really holds
  function automatic logic [ACC_W-1:0] widen(
    input logic [ACC_W-1:0] v, input pwa_kind_t k);
    case (k)
      KIND_BYTE: widen = {{(ACC_W-BYTE_W){v[BYTE_W-1]}}, v[BYTE_W-1:0]};
      KIND_WORD: widen = {{(ACC_W-WORD_W){v[WORD_W-1]}}, v[WORD_W-1:0]};
      default: widen = v;
    endcase
  endfunction : widen

  // keep only the operand's own bits, upper bits zero
  function automatic logic [ACC_W-1:0] clip(
    input logic [ACC_W-1:0] v, input pwa_kind_t k);
    case (k)
      KIND_BYTE: clip = {{(ACC_W-BYTE_W){1'b0}}, v[BYTE_W-1:0]};
      KIND_WORD: clip = {{(ACC_W-WORD_W){1'b0}}, v[WORD_W-1:0]};
      default: clip = v;
    endcase
  endfunction : clip

  // magnitude of a signed word; the most negative value maps to itself
  function automatic logic [ACC_W-1:0] mag(input logic [ACC_W-1:0] v);
    mag = v[ACC_W-1] ? ACC_W'(-v) : v;
  endfunction : mag

  // operand and arithmetic helpers
  logic accept;
  logic [ACC_W-1:0] opnd;
  logic [ACC_W-1:0] add_res;
  logic [ACC_W-1:0] sub_res;
  logic [2*ACC_W-1:0] prod;
  logic mul_ovf;
  logic div_zero;
  logic div_ovf;
  logic [ACC_W-1:0] cmp_a;
  logic [ACC_W-1:0] cmp_b;
  logic cmp_eq;
  logic cmp_lt;
  logic cmp_gt;
  logic [ACC_W-1:0] mem_up;
  logic [ACC_W-1:0] mem_dn;
  logic [ACC_W-1:0] shifted;
  logic fits;

  // datapath terms shared by the command decode and the checks below
  assign accept = i_req_valid && s_reg.ready;
  assign opnd = widen(i_req.value, i_req.kind); // [RL1] [RL9]
  assign add_res = s_reg.acc + opnd; // [RL1]
  assign sub_res = s_reg.acc - opnd; // [RL2]
  // sign-extend both sides so the full-width product is exact
  assign prod = {{ACC_W{s_reg.acc[ACC_W-1]}}, s_reg.acc} *
                {{ACC_W{opnd[ACC_W-1]}}, opnd}; // [RL3]
  // product must be a sign extension of its low word to fit
  assign mul_ovf = (prod[2*ACC_W-1:ACC_W-1] != {(ACC_W+1){1'b0}}) &&
                   (prod[2*ACC_W-1:ACC_W-1] != {(ACC_W+1){1'b1}}); // [RL21]
  assign div_zero = (opnd == ACC_RST); // [RL21]
  // the one quotient that cannot be held in the accumulator
  assign div_ovf = (s_reg.acc == ACC_MIN) && (opnd == ACC_NEG1);
  // compare only the bits the operand holds, both sides signed
  assign cmp_a = widen(s_reg.acc, i_req.kind); // [RL17]
  assign cmp_b = opnd; // [RL17]
  assign cmp_eq = (cmp_a == cmp_b); // [RL18]
  assign cmp_lt = $signed(cmp_a) < $signed(cmp_b); // [RL19]
  assign cmp_gt = $signed(cmp_a) > $signed(cmp_b); // [RL20]
  // memory operands wrap inside their own width
  assign mem_up = clip(i_req.value + ACC_ONE, i_req.kind); // [RL10]
  assign mem_dn = clip(i_req.value - ACC_ONE, i_req.kind); // [RL13]
  // one restoring division step per cycle
  assign shifted = {s_reg.part[ACC_W-2:0], s_reg.quo[ACC_W-1]};
  assign fits = (shifted >= s_reg.dsr);

  // next-state logic for the whole block
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.reject = 1'b0;
    s_next.wr.valid = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        if (accept) begin
          s_next.done = 1'b1;
          case (i_req.cmd)
            CMD_LOAD: begin
              s_next.acc = opnd;
              s_next.lmode = 1'b0;
            end
            CMD_ADD: begin
              s_next.acc = add_res; // [RL1]
              s_next.lmode = 1'b0;
            end
            CMD_SUB: begin
              s_next.acc = sub_res; // [RL2]
              s_next.lmode = 1'b0;
            end
            CMD_MUL: begin
              // an overflowing product leaves the accumulator untouched
              if (!mul_ovf) begin
                s_next.acc = prod[ACC_W-1:0]; // [RL3]
              end
              s_next.err.mul = mul_ovf; // [RL4] [RL21]
              s_next.lmode = 1'b0;
            end
            CMD_DIV, CMD_REMAINDER_OP: begin
              s_next.lmode = 1'b0;
              if (i_req.cmd == CMD_DIV && (div_zero || div_ovf)) begin
                s_next.err.div = 1'b1; // [RL6] [RL21]
              end else if (i_req.cmd == CMD_REMAINDER_OP && div_zero) begin
                s_next.err.rem = 1'b1; // [RL8] [RL21]
              end else begin
                // start the iterative divider on magnitudes
                s_next.done = 1'b0;
                s_next.ready = 1'b0;
                s_next.st = ST_DIV;
                s_next.quo = mag(s_reg.acc);
                s_next.dsr = mag(opnd);
                s_next.part = ACC_RST;
                s_next.cnt = '0;
                s_next.q_neg = s_reg.acc[ACC_W-1] ^ opnd[ACC_W-1];
                s_next.r_neg = s_reg.acc[ACC_W-1];
                s_next.is_rem = (i_req.cmd == CMD_REMAINDER_OP);
              end
            end
            CMD_OPERAND_STEP_UP, CMD_OPERAND_STEP_DOWN: begin
              // a constant has no storage to write back to
              if (i_req.kind == KIND_CONST) begin
                s_next.reject = 1'b1; // [RL9]
                s_next.done = 1'b0;
              end else begin
                s_next.wr.valid = 1'b1;
                s_next.wr.kind = i_req.kind;
                s_next.wr.data = (i_req.cmd == CMD_OPERAND_STEP_UP) ?
                                 mem_up : mem_dn; // [RL10] [RL13]
              end
            end
            CMD_ACCUMULATOR_STEP_UP: begin
              s_next.acc = s_reg.acc + ACC_ONE; // [RL11]
              s_next.lmode = 1'b0;
            end
            CMD_ACCUMULATOR_STEP_DOWN: begin
              s_next.acc = s_reg.acc - ACC_ONE; // [RL14]
              s_next.lmode = 1'b0;
            end
            CMD_INDEX_STEP_UP: begin
              s_next.idx = s_reg.idx + IDX_W'(1); // [RL12]
            end
            CMD_INDEX_STEP_DOWN: begin
              s_next.idx = s_reg.idx - IDX_W'(1); // [RL15]
            end
            CMD_CMP_EQ: begin
              s_next.lacc = cmp_eq; // [RL16] [RL18]
              s_next.lmode = 1'b1;
            end
            CMD_CMP_LT: begin
              s_next.lacc = cmp_lt; // [RL16] [RL19]
              s_next.lmode = 1'b1;
            end
            CMD_CMP_GT: begin
              s_next.lacc = cmp_gt; // [RL16] [RL20]
              s_next.lmode = 1'b1;
            end
            default: begin
              s_next.done = 1'b1;
            end
          endcase
        end
      end
      ST_DIV: begin
        if (fits) begin
          s_next.part = shifted - s_reg.dsr;
        end else begin
          s_next.part = shifted;
        end
        s_next.quo = {s_reg.quo[ACC_W-2:0], fits};
        s_next.cnt = s_reg.cnt + CNT_W'(1);
        if (s_reg.cnt == DIV_LAST) begin
          s_next.st = ST_FIX;
        end
      end
      ST_FIX: begin
        // restore signs: quotient truncates, remainder follows dividend
        if (s_reg.is_rem) begin
          s_next.acc = s_reg.r_neg ? ACC_W'(-s_reg.part) :
                       s_reg.part; // [RL7]
          s_next.err.rem = 1'b0; // [RL8]
        end else begin
          s_next.acc = s_reg.q_neg ? ACC_W'(-s_reg.quo) :
                       s_reg.quo; // [RL5]
          s_next.err.div = 1'b0; // [RL6]
        end
        s_next.done = 1'b1;
        s_next.ready = 1'b1;
        s_next.st = ST_IDLE;
      end
      default: begin
        s_next = RST_S;
      end
    endcase
  end

  // single state register, synchronous reset
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_reg <= RST_S;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs come straight from the state register
  assign o_ready = s_reg.ready;
  assign o_done = s_reg.done;
  assign o_reject = s_reg.reject;
  assign o_acc = s_reg.acc;
  assign o_idx = s_reg.idx;
  assign o_logic_acc = s_reg.lacc;
  assign o_logic_mode = s_reg.lmode;
  assign o_err = s_reg.err;
  assign o_wr = s_reg.wr;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_add_sum: assert property ( // [RL1]
    accept && i_req.cmd == CMD_ADD |=> o_done && o_acc == $past(add_res))
    else $error("add result wrong");

  a_sub_diff: assert property ( // [RL2]
    accept && i_req.cmd == CMD_SUB |=> o_acc == $past(sub_res) && !o_logic_mode)
    else $error("subtract result wrong");

  a_mul_flag: assert property ( // [RL4]
    accept && i_req.cmd == CMD_MUL |=> o_err.mul == $past(mul_ovf) && o_done)
    else $error("multiply flag wrong");

  a_div_zero_err: assert property ( // [RL21]
    accept && i_req.cmd == CMD_DIV && div_zero
    |=> o_err.div && o_done && $stable(o_acc))
    else $error("zero divisor not flagged");

  a_div_bound: assert property ( // [RL5]
    accept && i_req.cmd == CMD_DIV && !div_zero && !div_ovf
    |=> !o_ready [*8] ##[26:26] o_done && !o_err.div)
    else $error("divide did not finish in 34 cycles");

  a_rem_clear: assert property ( // [RL8]
    accept && i_req.cmd == CMD_REMAINDER_OP && !div_zero
    |-> ##34 o_done && !o_err.rem)
    else $error("remainder flag not cleared");

  a_mem_step: assert property ( // [RL10]
    accept && i_req.cmd == CMD_OPERAND_STEP_UP && i_req.kind != KIND_CONST
    |=> o_wr.valid && o_wr.data == $past(mem_up)
    ##1 (!o_wr.valid || $past(accept)))
    else $error("operand step up write wrong");

  a_const_refused: assert property ( // [RL9]
    accept && i_req.cmd == CMD_OPERAND_STEP_DOWN && i_req.kind == KIND_CONST
    |=> o_reject && !o_wr.valid && !o_done)
    else $error("constant step not refused");

  a_idx_up: assert property ( // [RL12]
    accept && i_req.cmd == CMD_INDEX_STEP_UP
    |=> o_idx == IDX_W'($past(o_idx) + IDX_W'(1)))
    else $error("index step up wrong");

  a_acc_down: assert property ( // [RL14]
    accept && i_req.cmd == CMD_ACCUMULATOR_STEP_DOWN
    |=> o_acc == ACC_W'($past(o_acc) - ACC_ONE))
    else $error("accumulator step down wrong");

  a_cmp_logic: assert property ( // [RL16]
    accept && i_req.cmd == CMD_CMP_LT
    |=> o_logic_mode && o_logic_acc == $past(cmp_lt))
    else $error("compare result wrong");

  // main scenarios
  c_div_run: cover property (
    accept && i_req.cmd == CMD_DIV ##34 o_done);
  c_mul_ovf: cover property (
    accept && i_req.cmd == CMD_MUL && mul_ovf);
  c_cmp_true: cover property (
    accept && i_req.cmd == CMD_CMP_GT ##1 o_logic_acc);
  c_mem_wr: cover property (o_wr.valid && o_wr.kind == KIND_BYTE);
endmodule : pwa_alu

// ===== hw/pwa_pkg.sv
// shared constants and types of the word-accumulator arithmetic block
// How it works
// [RL1] add: widen operand, sum into word accumulator
// [RL2] subtract: widen operand, difference into accumulator
// [RL3] multiply: widen operand, product into accumulator
// [RL4] multiply error flag set or cleared each time
// [RL5] divide: widen operand, quotient into accumulator
// [RL6] divide error flag set or cleared each time
// [RL7] remainder: widen operand, remainder into accumulator
// [RL8] remainder error flag set or cleared each time
// [RL9] constants allowed except for operand step commands
// [RL10] operand step up: read, add one, write back
// [RL11] accumulator step up adds one to accumulator
// [RL12] index step up adds one to index
// [RL13] operand step down: read, subtract one, write back
// [RL14] accumulator step down subtracts one from accumulator
// [RL15] index step down subtracts one from index
// [RL16] compares switch to logic mode, write boolean
// [RL17] compare only the operand's own bit width
// [RL18] equal compare gives one when values match
// [RL19] less-than gives one only when accumulator below
// [RL20] greater-than gives one only when accumulator above
// [RL21] zero divisor or product overflow is error
package pwa_pkg;
  localparam int ACC_W = 32;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int IDX_W_DEF = 16;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] DIV_LAST = 6'h1F;
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [ACC_W-1:0] ACC_ONE = 32'h0000_0001;
  localparam logic [ACC_W-1:0] ACC_MIN = 32'h8000_0000;
  localparam logic [ACC_W-1:0] ACC_NEG1 = 32'hFFFF_FFFF;

  // decoded commands issued by the instruction sequencer
  typedef enum logic [3:0] {
    CMD_NOP, CMD_LOAD, CMD_ADD, CMD_SUB, CMD_MUL, CMD_DIV, CMD_REMAINDER_OP,
    CMD_OPERAND_STEP_UP, CMD_OPERAND_STEP_DOWN,
    CMD_ACCUMULATOR_STEP_UP, CMD_ACCUMULATOR_STEP_DOWN,
    CMD_INDEX_STEP_UP, CMD_INDEX_STEP_DOWN,
    CMD_CMP_EQ, CMD_CMP_LT, CMD_CMP_GT
  } pwa_cmd_t;

  // operand kind: memory byte, word, double word or constant
  typedef enum logic [1:0] {
    KIND_BYTE, KIND_WORD, KIND_DWORD, KIND_CONST
  } pwa_kind_t;

  typedef struct packed {
    pwa_cmd_t cmd;
    pwa_kind_t kind;
    logic [ACC_W-1:0] value;
  } pwa_req_t;

  typedef struct packed {
    logic mul;
    logic div;
    logic rem;
  } pwa_err_t;

  typedef struct packed {
    logic valid;
    pwa_kind_t kind;
    logic [ACC_W-1:0] data;
  } pwa_wr_t;
endpackage : pwa_pkg

// ===== sim/pwa_seq_model.sv
// sequencer model that issues one decoded command at a time
`timescale 1ns/1ns
module pwa_seq_model (
  // clock
  input wire logic i_clk,
  // answer from the datapath
  input wire logic i_ready,
  input wire logic i_done,
  input wire logic i_reject,
  input wire pwa_pkg::pwa_wr_t i_wr,
  // command to the datapath
  output logic o_req_valid,
  output pwa_pkg::pwa_req_t o_req
);
  import pwa_pkg::*;

  pwa_wr_t wr_seen;
  int lat;

  // idle request at time zero
  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
    wr_seen = '0;
    lat = 0;
  end

  // hold the command until an edge samples ready high, then drop it
  task automatic issue(input pwa_cmd_t c, input pwa_kind_t k,
                       input logic [ACC_W-1:0] v);
    int n;
    @(negedge i_clk);
    o_req_valid = 1'b1;
    o_req = '{cmd: c, kind: k, value: v};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ready !== 1'b1 && n < 50);
    @(negedge i_clk);
    // released operand is inverted so stale data cannot pass for fresh
    o_req_valid = 1'b0;
    o_req = '{cmd: CMD_NOP, kind: k, value: ~v};
    lat = 1;
    while (i_done !== 1'b1 && i_reject !== 1'b1 && lat < 40) begin
      @(negedge i_clk);
      lat++;
    end
    wr_seen = i_wr;
  endtask : issue
endmodule : pwa_seq_model

// ===== sim/tb_pwa_alu.sv
// self-checking bench of the word-accumulator datapath
`timescale 1ns/1ns
module tb_pwa_alu;
  import pwa_pkg::*;

  // one command with the accumulator and {lacc,mul,div,rem} it leaves
  typedef struct {
    pwa_cmd_t cmd;
    pwa_kind_t kind;
    logic [31:0] val;
    logic [31:0] acc;
    logic [3:0] flags;
  } pwa_row_t;

  logic i_clk;
  logic i_rstn;
  logic req_valid;
  pwa_req_t req;
  logic ready;
  logic done;
  logic reject;
  logic lacc;
  logic lmode;
  logic [ACC_W-1:0] acc;
  logic [15:0] idx;
  pwa_err_t err;
  pwa_wr_t wr;
  int failures;
  int compares;

  // chained rows: each starts from the accumulator the last one left
  pwa_row_t rows [34] = '{
    '{CMD_LOAD, KIND_DWORD, 32'h2710, 32'h2710, 4'h0},
    '{CMD_NOP, KIND_DWORD, 32'h5, 32'h2710, 4'h0},
    '{CMD_ADD, KIND_WORD, 32'hC8, 32'h27D8, 4'h0},
    '{CMD_SUB, KIND_WORD, 32'hC8, 32'h2710, 4'h0},
    '{CMD_LOAD, KIND_CONST, 32'h64, 32'h64, 4'h0},
    '{CMD_MUL, KIND_WORD, 32'h14, 32'h7D0, 4'h0},
    '{CMD_DIV, KIND_WORD, 32'h14, 32'h64, 4'h0},
    '{CMD_LOAD, KIND_WORD, 32'h32, 32'h32, 4'h0},
    '{CMD_REMAINDER_OP, KIND_CONST, 32'hF, 32'h5, 4'h0},
    '{CMD_ADD, KIND_BYTE, 32'hFF, 32'h4, 4'h0},
    '{CMD_SUB, KIND_WORD, 32'hFFFE, 32'h6, 4'h0},
    '{CMD_MUL, KIND_CONST, 32'h7FFFFFFF, 32'h6, 4'h4},
    '{CMD_MUL, KIND_CONST, 32'h2, 32'hC, 4'h0},
    '{CMD_DIV, KIND_CONST, 32'h0, 32'hC, 4'h2},
    '{CMD_REMAINDER_OP, KIND_CONST, 32'h0, 32'hC, 4'h3},
    '{CMD_DIV, KIND_BYTE, 32'hFD, 32'hFFFFFFFC, 4'h1},
    '{CMD_REMAINDER_OP, KIND_CONST, 32'h5, 32'hFFFFFFFC, 4'h0},
    '{CMD_ACCUMULATOR_STEP_UP, KIND_DWORD, 32'h0, 32'hFFFFFFFD, 4'h0},
    '{CMD_ACCUMULATOR_STEP_DOWN, KIND_DWORD, 32'h0, 32'hFFFFFFFC, 4'h0},
    '{CMD_LOAD, KIND_CONST, 32'h80000000, 32'h80000000, 4'h0},
    '{CMD_DIV, KIND_CONST, 32'hFFFFFFFF, 32'h80000000, 4'h2},
    '{CMD_REMAINDER_OP, KIND_CONST, 32'hFFFFFFFF, 32'h0, 4'h2},
    '{CMD_DIV, KIND_CONST, 32'h1, 32'h0, 4'h0},
    '{CMD_LOAD, KIND_CONST, 32'h3E80, 32'h3E80, 4'h0},
    '{CMD_CMP_EQ, KIND_DWORD, 32'h3A98, 32'h3E80, 4'h0},
    '{CMD_CMP_LT, KIND_DWORD, 32'h3A98, 32'h3E80, 4'h0},
    '{CMD_CMP_GT, KIND_DWORD, 32'h3A98, 32'h3E80, 4'h8},
    '{CMD_CMP_EQ, KIND_CONST, 32'h3E80, 32'h3E80, 4'h8},
    '{CMD_CMP_LT, KIND_DWORD, 32'h3E81, 32'h3E80, 4'h8},
    '{CMD_CMP_EQ, KIND_BYTE, 32'h80, 32'h3E80, 4'h8},
    '{CMD_CMP_LT, KIND_BYTE, 32'h0, 32'h3E80, 4'h8},
    '{CMD_CMP_GT, KIND_WORD, 32'h3E7F, 32'h3E80, 4'h8},
    '{CMD_CMP_GT, KIND_BYTE, 32'h0, 32'h3E80, 4'h0},
    '{CMD_CMP_EQ, KIND_WORD, 32'h0, 32'h3E80, 4'h0}
  };

  pwa_alu dut_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_req_valid(req_valid), .i_req(req),
    .o_ready(ready), .o_done(done), .o_reject(reject), .o_acc(acc),
    .o_idx(idx), .o_logic_acc(lacc), .o_logic_mode(lmode), .o_err(err),
    .o_wr(wr)
  );

  pwa_seq_model seq_u (
    .i_clk(i_clk), .i_ready(ready), .i_done(done), .i_reject(reject),
    .i_wr(wr), .o_req_valid(req_valid), .o_req(req)
  );

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // operand step: write-back pulse carries the wrapped operand
  task automatic step_op(input pwa_cmd_t c, input pwa_kind_t k,
                         input logic [31:0] v, input logic [31:0] d);
    seq_u.issue(c, k, v);
    check("wr_valid", seq_u.wr_seen.valid, 1'b1);
    check("wr_kind", seq_u.wr_seen.kind, k);
    check("wr_data", seq_u.wr_seen.data, d);
    check("acc", acc, 32'h3E81);
  endtask : step_op

  // free-running 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // a hang costs at most ten thousand cycles before the verdict
  initial begin
    #100000;
    failures++;
    conclude();
  end

  initial begin
    i_rstn = 1'b0;
    failures = 0;
    compares = 0;
    repeat (3) @(negedge i_clk);
    i_rstn = 1'b1;
    check("ready", ready, 1'b1);
    check("acc", acc, 32'h0);
    check("idx", idx, 32'h0);
    check("err", err, 3'h0);
    foreach (rows[i]) begin
      seq_u.issue(rows[i].cmd, rows[i].kind, rows[i].val);
      check("acc", acc, rows[i].acc);
      check("err", err, rows[i].flags[2:0]);
      check("lacc", lacc, rows[i].flags[3]);
      check("mode", lmode, rows[i].cmd >= CMD_CMP_EQ);
      if (rows[i].cmd < CMD_DIV || rows[i].cmd > CMD_REMAINDER_OP) begin
        check("latency", seq_u.lat, 1);
      end
    end
    // index register wraps inside its own width
    seq_u.issue(CMD_INDEX_STEP_DOWN, KIND_DWORD, 32'h0);
    check("idx", idx, 32'hFFFF);
    seq_u.issue(CMD_INDEX_STEP_UP, KIND_DWORD, 32'h0);
    seq_u.issue(CMD_INDEX_STEP_UP, KIND_DWORD, 32'h0);
    check("idx", idx, 32'h1);
    seq_u.issue(CMD_ACCUMULATOR_STEP_UP, KIND_DWORD, 32'h0);
    check("mode", lmode, 1'b0);
    check("acc", acc, 32'h3E81);
    step_op(CMD_OPERAND_STEP_UP, KIND_BYTE, 32'hFF, 32'h0);
    step_op(CMD_OPERAND_STEP_DOWN, KIND_WORD, 32'h0, 32'hFFFF);
    step_op(CMD_OPERAND_STEP_UP, KIND_DWORD, 32'h7FFFFFFF, 32'h80000000);
    // constants are refused for operand steps
    seq_u.issue(CMD_OPERAND_STEP_DOWN, KIND_CONST, 32'h5);
    check("reject", reject, 1'b1);
    check("wr_valid", seq_u.wr_seen.valid, 1'b0);
    // full divide runs the stepping divider
    seq_u.issue(CMD_DIV, KIND_CONST, 32'h3);
    check("latency", seq_u.lat, 34);
    check("acc", acc, 32'h14D5);
    // second reset in mid-run
    @(negedge i_clk);
    i_rstn = 1'b0;
    @(negedge i_clk);
    i_rstn = 1'b1;
    check("acc", acc, 32'h0);
    check("idx", idx, 32'h0);
    conclude();
  end
endmodule : tb_pwa_alu
